// ---- common/frc_consts.svh ----
`ifndef FRC_CONSTS_SVH
`define FRC_CONSTS_SVH
`define FRC_CLK_HZ 10000000
`define FRC_PHASE_LOSS_MS 1000
`define FRC_NCAUSE 23
`define FRC_C_OC_ACC 5'h00
`define FRC_C_OC_STD 5'h01
`define FRC_C_OC_DEC 5'h02
`define FRC_C_OV_ACC 5'h03
`define FRC_C_OV_STD 5'h04
`define FRC_C_OV_DEC 5'h05
`define FRC_C_MOTOR_HEAT 5'h06
`define FRC_C_DRIVE_HEAT 5'h07
`define FRC_C_INST_PLOSS 5'h08
`define FRC_C_LOW_BUS 5'h09
`define FRC_C_SINK_HOT 5'h0A
`define FRC_C_BRAKE 5'h0B
`define FRC_C_GROUND 5'h0C
`define FRC_C_EXT_HEAT 5'h0D
`define FRC_C_STALL 5'h0E
`define FRC_C_OPTION 5'h0F
`define FRC_C_COMM_OPT 5'h10
`define FRC_C_PARAM_STORE 5'h11
`define FRC_C_THERMISTOR 5'h12
`define FRC_C_OUT_PHASE 5'h13
`define FRC_C_IN_PHASE 5'h14
`define FRC_C_RETRY_EXCESS 5'h15
`define FRC_C_OTHER 5'h16
`define FRC_CODE_NORMAL 4'h0
`define FRC_CODE_OTHER 4'hF
`define FRC_REG_CTRL 8'h00
`define FRC_REG_RETRY 8'h04
`define FRC_REG_STATUS 8'h08
`define FRC_REG_RECORD 8'h0C
`define FRC_REG_INT_STAT 8'h10
`define FRC_REG_INT_MASK 8'h14
`define FRC_REG_CMD 8'h18
`define FRC_LIMIT_RST 7'h00
`define FRC_WAIT_RST 4'h1
`define FRC_WAIT_MAX 4'hA
`define FRC_LIMIT_OUT_MIN 7'h65
`define FRC_LIMIT_OUT_BASE 7'h64
`define FRC_OUT_GUARD_RST 1'b1
`define FRC_IN_GUARD_RST 1'b0
`define FRC_EV_TRIP 0
`define FRC_EV_RETRY 1
`define FRC_EV_EXCESS 2
`define FRC_EV_SUCCESS 3
`endif

// ---- common/frc_pkg.sv ----
package frc_pkg;
	typedef enum logic [1:0] {
		FRC_RUN = 2'b00,
		FRC_WAIT = 2'b01,
		FRC_RETRY = 2'b11,
		FRC_HOLD = 2'b10
	} frc_state_t;

	typedef struct packed {
		logic [3:0] power_fail_stop_select;
		logic input_phase_guard_enable;
		logic output_phase_guard_enable;
		logic [1:0] code_out_select;
		logic [2:0] retry_cause_select;
	} frc_ctrl_t;

	typedef struct packed {
		logic [3:0] retry_wait;
		logic [6:0] retry_limit;
	} frc_retry_t;
endpackage

// ---- src/frc_top.sv ----
// Summary of operation
// - Retry cause select gates which fault causes may retry.
// - During a retry sequence only the first fault is kept in the record.
// - Retry reset keeps thermal and brake duty data; power-on reset clears them.
// - No retry for a parameter storage fault seen at power-on.
// - Non-selected fault during retry wait stops retrying, fault stays shown.
// - Faults injected by the test function never retry.
// - Code select 0 none, 1 always with zero normally, 2 only on fault.
// - Select 2 shows assigned terminal functions while fault-free.
// - Code is four bits on four lines, bit one turns transistor on.
// - Codes: normal 0, overcurrent 1-3, overvoltage 4, heat 5/6, power loss 7.
// - Codes: low bus 8, heatsink 9, brake A, ground B, C, D, options E, else F.
// - With select 1 or 2 a fault overrides terminal function assignment.
// - Output phase guard defaults on; off suppresses output phase trip.
// - Input phase guard, default off, trips after one second of phase loss.
// - With power-fail stop active, input phase loss starts deceleration instead.
// - Loss of first and second input phases shuts output off instead.
// - Retry failures beyond the retry limit raise the retry excess trip.
// - Retry starts only after the zero to ten second wait.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "frc_consts.svh"

module frc_top #(
	parameter int unsigned SEC_CYCLES = `FRC_CLK_HZ,
	parameter int unsigned PHASE_CYCLES = (`FRC_CLK_HZ / 1000) * `FRC_PHASE_LOSS_MS
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	input wire logic [`FRC_NCAUSE-1:0] i_fault,
	input wire logic [3:0] i_term_func,
	input wire logic [2:0] i_in_phase_loss,
	input wire logic i_out_phase_loss,
	output logic [3:0] o_term_on,
	output logic o_trip,
	output logic o_retry_active,
	output logic o_retry_reset,
	output logic o_clear_accum,
	output logic o_pf_decel,
	output logic o_out_shutoff,
	output logic o_irq
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------

	frc_pkg::frc_ctrl_t ctrl;
	frc_pkg::frc_retry_t rcfg;
	frc_pkg::frc_state_t state;
	frc_pkg::frc_state_t next_state;

	logic [3:0] int_stat;
	logic [3:0] int_mask;
	logic [3:0] record_code;
	logic record_valid;
	logic [3:0] code;
	logic [3:0] next_code;
	logic code_valid;
	logic next_code_valid;
	logic [6:0] retry_cnt;
	logic [6:0] next_retry_cnt;
	logic [6:0] eff_limit;
	logic out_during_retry;
	logic boot;

	logic [23:0] tick_cnt;
	logic [5:0] sec_cnt;
	logic [23:0] ph_cnt;
	logic ph_persist;
	logic rs_loss;
	logic ilf_trip;
	logic lf_trip;

	logic [2:0] in_meta;
	logic [2:0] in_sync;
	logic out_meta;
	logic out_sync;

	logic [`FRC_NCAUSE-1:0] inj_vec;
	logic inj_flag;
	logic [`FRC_NCAUSE-1:0] cur_fault;
	logic [`FRC_NCAUSE-1:0] elig_mask;
	logic [4:0] first;
	logic any_fault;
	logic retry_ok;

	logic trip_ev;
	logic start_ev;
	logic excess_ev;
	logic ok_ev;
	logic rec_load;
	logic [3:0] events;

	logic wr;
	logic setup;
	logic sw_reset;
	logic inj_req;
	logic [31:0] next_prdata;
	logic next_slverr;
	logic [3:0] next_term;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------

	function automatic logic cause_eligible(input logic [2:0] sel, input logic [4:0] c);
		logic oc;
		logic ov;
		logic heat;
		logic listed;
		logic e;
		oc = (c == `FRC_C_OC_ACC) | (c == `FRC_C_OC_STD) | (c == `FRC_C_OC_DEC);
		ov = (c == `FRC_C_OV_ACC) | (c == `FRC_C_OV_STD) | (c == `FRC_C_OV_DEC);
		heat = (c == `FRC_C_MOTOR_HEAT) | (c == `FRC_C_DRIVE_HEAT) |
			(c == `FRC_C_EXT_HEAT) | (c == `FRC_C_THERMISTOR);
		// Heatsink, output phase and retry excess never retry
		listed = (c != `FRC_C_SINK_HOT) & (c != `FRC_C_OUT_PHASE) &
			(c != `FRC_C_RETRY_EXCESS);
		case (sel)
			3'h0: e = listed;
			3'h1: e = oc;
			3'h2: e = ov;
			3'h3: e = oc | ov;
			3'h4: e = listed & ~heat;
			3'h5: e = (c == `FRC_C_OC_ACC) | (c == `FRC_C_OC_DEC);
			default: e = 1'b0;
		endcase
		return e;
	endfunction

	function automatic logic [3:0] code_of(input logic [4:0] c);
		logic [3:0] r;
		case (c)
			`FRC_C_OC_ACC: r = 4'h1;
			`FRC_C_OC_STD: r = 4'h2;
			`FRC_C_OC_DEC: r = 4'h3;
			`FRC_C_OV_ACC, `FRC_C_OV_STD, `FRC_C_OV_DEC: r = 4'h4;
			`FRC_C_MOTOR_HEAT: r = 4'h5;
			`FRC_C_DRIVE_HEAT: r = 4'h6;
			`FRC_C_INST_PLOSS: r = 4'h7;
			`FRC_C_LOW_BUS: r = 4'h8;
			`FRC_C_SINK_HOT: r = 4'h9;
			`FRC_C_BRAKE: r = 4'hA;
			`FRC_C_GROUND: r = 4'hB;
			`FRC_C_EXT_HEAT: r = 4'hC;
			`FRC_C_STALL: r = 4'hD;
			`FRC_C_OPTION, `FRC_C_COMM_OPT: r = 4'hE;
			default: r = `FRC_CODE_OTHER;
		endcase
		return r;
	endfunction

	// Lowest index wins when several causes arrive together
	function automatic logic [4:0] first_cause(input logic [`FRC_NCAUSE-1:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = `FRC_NCAUSE - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			in_meta <= 3'h0;
			in_sync <= 3'h0;
			out_meta <= 1'b0;
			out_sync <= 1'b0;
		end else begin
			in_meta <= i_in_phase_loss;
			in_sync <= in_meta;
			out_meta <= i_out_phase_loss;
			out_sync <= out_meta;
		end
	end

	// ------------------------------------------------------------
	// Phase loss guards
	// ------------------------------------------------------------

	always_ff @(posedge i_core_clk) begin
		if (i_rst || !ctrl.input_phase_guard_enable || in_sync == 3'h0) begin
			ph_cnt <= 24'h000000;
		end else if (!ph_persist) begin
			ph_cnt <= ph_cnt + 24'h000001;
		end
	end

	// Gated by the live loss so a stale count cannot trip once the phase returns
	assign ph_persist = (ph_cnt == 24'(PHASE_CYCLES - 1)) & (in_sync != 3'h0) & ctrl.input_phase_guard_enable;
	assign rs_loss = in_sync[0] & in_sync[1];
	assign ilf_trip = ph_persist & ~rs_loss & (ctrl.power_fail_stop_select == 4'h0);
	assign lf_trip = out_sync & ctrl.output_phase_guard_enable;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_pf_decel <= 1'b0;
			o_out_shutoff <= 1'b0;
		end else begin
			o_pf_decel <= ph_persist & ~rs_loss & (ctrl.power_fail_stop_select != 4'h0);
			o_out_shutoff <= ph_persist & rs_loss;
		end
	end

	// ------------------------------------------------------------
	// Fault gathering and eligibility
	// ------------------------------------------------------------

	always_comb begin
		cur_fault = i_fault | inj_vec;
		cur_fault[`FRC_C_OUT_PHASE] = lf_trip | inj_vec[`FRC_C_OUT_PHASE];
		cur_fault[`FRC_C_IN_PHASE] = ilf_trip | inj_vec[`FRC_C_IN_PHASE];
		cur_fault[`FRC_C_RETRY_EXCESS] = 1'b0;
	end

	genvar gi;
	generate
		for (gi = 0; gi < `FRC_NCAUSE; gi++) begin : g_elig
			assign elig_mask[gi] = cause_eligible(ctrl.retry_cause_select, 5'(gi));
		end
	endgenerate

	assign first = first_cause(cur_fault);
	assign any_fault = |cur_fault;
	assign eff_limit = (rcfg.retry_limit >= `FRC_LIMIT_OUT_MIN) ?
		(rcfg.retry_limit - `FRC_LIMIT_OUT_BASE) : rcfg.retry_limit;
	assign out_during_retry = (rcfg.retry_limit >= `FRC_LIMIT_OUT_MIN);
	assign retry_ok = elig_mask[first] & ~inj_flag & (eff_limit != 7'h00) &
		~(boot & (first == `FRC_C_PARAM_STORE));

	// Power-on window ends at the first fault-free cycle
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			boot <= 1'b1;
		end else if (!any_fault) begin
			boot <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Retry sequencer
	// ------------------------------------------------------------

	always_comb begin
		next_state = state;
		next_code = code;
		next_code_valid = code_valid;
		next_retry_cnt = retry_cnt;
		trip_ev = 1'b0;
		start_ev = 1'b0;
		excess_ev = 1'b0;
		ok_ev = 1'b0;
		rec_load = 1'b0;
		unique case (state)
			frc_pkg::FRC_RUN, frc_pkg::FRC_RETRY: begin
				if (any_fault) begin
					trip_ev = 1'b1;
					rec_load = (state == frc_pkg::FRC_RUN);
					next_code_valid = 1'b1;
					if (retry_ok && retry_cnt < eff_limit) begin
						next_state = frc_pkg::FRC_WAIT;
						next_code = code_of(first);
					end else if (retry_ok) begin
						next_state = frc_pkg::FRC_HOLD;
						next_code = code_of(`FRC_C_RETRY_EXCESS);
						excess_ev = 1'b1;
					end else begin
						next_state = frc_pkg::FRC_HOLD;
						next_code = code_of(first);
					end
				end else if (state == frc_pkg::FRC_RETRY &&
					sec_cnt >= {rcfg.retry_wait, 2'b00}) begin
					// Healthy for four waits counts as a successful retry
					next_state = frc_pkg::FRC_RUN;
					next_retry_cnt = 7'h00;
					ok_ev = 1'b1;
				end
			end
			frc_pkg::FRC_WAIT: begin
				if ((|(cur_fault & ~elig_mask)) || inj_flag) begin
					next_state = frc_pkg::FRC_HOLD;
				end else if (sec_cnt >= {2'b00, rcfg.retry_wait}) begin
					next_state = frc_pkg::FRC_RETRY;
					next_retry_cnt = retry_cnt + 7'h01;
					next_code = `FRC_CODE_NORMAL;
					next_code_valid = 1'b0;
					start_ev = 1'b1;
				end
			end
			frc_pkg::FRC_HOLD: begin
				next_state = frc_pkg::FRC_HOLD;
			end
		endcase
		if (sw_reset) begin
			next_state = frc_pkg::FRC_RUN;
			start_ev = 1'b0;
			next_retry_cnt = 7'h00;
			next_code = `FRC_CODE_NORMAL;
			next_code_valid = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state <= frc_pkg::FRC_RUN;
			code <= `FRC_CODE_NORMAL;
			code_valid <= 1'b0;
			retry_cnt <= 7'h00;
		end else begin
			state <= next_state;
			code <= next_code;
			code_valid <= next_code_valid;
			retry_cnt <= next_retry_cnt;
		end
	end

	// Seconds timer restarts on every state change
	always_ff @(posedge i_core_clk) begin
		if (i_rst || next_state != state) begin
			tick_cnt <= 24'h000000;
			sec_cnt <= 6'h00;
		end else if (tick_cnt == 24'(SEC_CYCLES - 1)) begin
			tick_cnt <= 24'h000000;
			if (sec_cnt != 6'h3F) begin
				sec_cnt <= sec_cnt + 6'h01;
			end
		end else begin
			tick_cnt <= tick_cnt + 24'h000001;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			record_code <= `FRC_CODE_NORMAL;
			record_valid <= 1'b0;
		end else if (rec_load) begin
			record_code <= code_of(first);
			record_valid <= 1'b1;
		end
	end

	// Retry reset spares thermal and brake duty accumulators
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_retry_reset <= 1'b0;
			o_clear_accum <= 1'b1;
		end else begin
			o_retry_reset <= start_ev;
			o_clear_accum <= sw_reset;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_trip <= 1'b0;
			o_retry_active <= 1'b0;
		end else begin
			o_trip <= (next_state == frc_pkg::FRC_HOLD) ||
				(next_state == frc_pkg::FRC_WAIT && out_during_retry);
			o_retry_active <= (next_state == frc_pkg::FRC_WAIT);
		end
	end

	// ------------------------------------------------------------
	// Code terminals
	// ------------------------------------------------------------

	always_comb begin
		unique case (ctrl.code_out_select)
			2'h1: next_term = code;
			2'h2: next_term = code_valid ? code : i_term_func;
			default: next_term = i_term_func;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_term_on <= 4'h0;
		end else begin
			o_term_on <= next_term;
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------

	assign events = {ok_ev, excess_ev, start_ev, trip_ev};

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			int_stat <= 4'h0;
			o_irq <= 1'b0;
		end else begin
			// A new event beats a clear in the same cycle
			if (wr && i_paddr == `FRC_REG_INT_STAT) begin
				int_stat <= (int_stat & ~i_pwdata[3:0]) | events;
			end else begin
				int_stat <= int_stat | events;
			end
			o_irq <= |(int_stat & int_mask);
		end
	end

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------

	assign wr = i_psel & i_penable & i_pwrite;
	assign setup = i_psel & ~i_penable;
	assign sw_reset = wr & (i_paddr == `FRC_REG_CMD) & i_pwdata[0];
	assign inj_req = wr & (i_paddr == `FRC_REG_CMD) & i_pwdata[1];
	assign o_pready = 1'b1;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ctrl <= '{power_fail_stop_select: 4'h0,
				input_phase_guard_enable: `FRC_IN_GUARD_RST,
				output_phase_guard_enable: `FRC_OUT_GUARD_RST,
				code_out_select: 2'h0, retry_cause_select: 3'h0};
		end else if (wr && i_paddr == `FRC_REG_CTRL) begin
			ctrl <= i_pwdata[10:0];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			rcfg <= '{retry_wait: `FRC_WAIT_RST, retry_limit: `FRC_LIMIT_RST};
		end else if (wr && i_paddr == `FRC_REG_RETRY) begin
			rcfg.retry_limit <= i_pwdata[6:0];
			// Waits above ten seconds clamp to ten
			rcfg.retry_wait <= (i_pwdata[11:8] > `FRC_WAIT_MAX) ? `FRC_WAIT_MAX : i_pwdata[11:8];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			int_mask <= 4'h0;
		end else if (wr && i_paddr == `FRC_REG_INT_MASK) begin
			int_mask <= i_pwdata[3:0];
		end
	end

	// Injected fault lasts one cycle and is flagged as a test
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			inj_vec <= '0;
			inj_flag <= 1'b0;
		end else begin
			inj_vec <= inj_req ? (`FRC_NCAUSE'(1) << i_pwdata[12:8]) : '0;
			inj_flag <= inj_req;
		end
	end

	always_comb begin
		next_prdata = 32'h00000000;
		next_slverr = 1'b0;
		case (i_paddr)
			`FRC_REG_CTRL: next_prdata = {21'h000000, ctrl};
			`FRC_REG_RETRY: next_prdata = {20'h00000, rcfg.retry_wait, 1'b0, rcfg.retry_limit};
			`FRC_REG_STATUS: next_prdata = {7'h00, boot, 1'b0, retry_cnt,
				6'h00, state, 3'h0, code_valid, code};
			`FRC_REG_RECORD: next_prdata = {27'h0000000, record_valid, record_code};
			`FRC_REG_INT_STAT: next_prdata = {28'h0000000, int_stat};
			`FRC_REG_INT_MASK: next_prdata = {28'h0000000, int_mask};
			`FRC_REG_CMD: next_prdata = 32'h00000000;
			default: next_slverr = 1'b1;
		endcase
	end

	// Read data captured in setup so pready can stay high
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_prdata <= 32'h00000000;
			o_pslverr <= 1'b0;
		end else if (setup) begin
			o_prdata <= next_prdata;
			o_pslverr <= next_slverr;
		end
	end

endmodule
`default_nettype wire

// ---- bench/frc_plc_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module frc_plc_model (
	input wire logic [3:0] i_term_on,
	output logic [3:0] o_code
);
	logic [3:0] line_lvl;
	// Transistor on pulls the pulled-up line low
	assign line_lvl = ~i_term_on;
	// Controller reads a low line as a one, bit3 line first
	assign o_code = {~line_lvl[3], ~line_lvl[2], ~line_lvl[1], ~line_lvl[0]};
endmodule

`default_nettype wire

// ---- bench/frc_top_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "frc_consts.svh"

module frc_top_chk #(
	parameter int unsigned SEC_CYCLES = 20,
	parameter int unsigned PHASE_CYCLES = 30
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic [`FRC_NCAUSE-1:0] i_fault,
	input wire logic [3:0] i_term_func,
	input wire logic [3:0] o_term_on,
	input wire logic o_trip,
	input wire logic o_retry_active,
	input wire logic o_retry_reset,
	input wire logic o_clear_accum,
	input wire logic o_pf_decel,
	input wire logic o_out_shutoff,
	input wire logic o_irq
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// ----------------------------------------
	// Code select snooped from bus writes
	// ----------------------------------------
	logic [1:0] sel;
	logic calm;
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			sel <= 2'h0;
		end else if (i_psel && i_penable && i_pwrite && o_pready && i_paddr == `FRC_REG_CTRL) begin
			sel <= i_pwdata[4:3];
		end
	end
	assign calm = !o_trip && !o_retry_active;
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	AST_CLR_AT_BOOT: assert property ($fell(i_rst) |-> o_clear_accum)
		else $error("accumulators not cleared at power-on");
	AST_RETRY_KEEPS: assert property (o_retry_reset |-> !o_clear_accum)
		else $error("retry reset cleared accumulators");
	AST_RETRY_AFTER_WAIT: assert property (o_retry_reset |-> $past(o_retry_active))
		else $error("retry without waiting period");
	AST_NORMAL_ZERO: assert property (sel == 2'h1 && $past(sel) == 2'h1 && calm && !$past(o_trip)
		&& !$past(o_retry_active) |-> o_term_on == 4'h0) else $error("code not zero in normal run");
	AST_SEL2_PASS: assert property (sel == 2'h2 && $past(sel) == 2'h2 && calm && !$past(o_trip)
		&& !$past(o_retry_active) |-> o_term_on == $past(i_term_func)) else $error("terminal function lost");
	AST_OC1_CODE: assert property ((sel == 2'h1 || sel == 2'h2) && calm && i_fault == 23'h1
		|-> ##2 o_term_on == 4'h1) else $error("wrong code for first overcurrent");
	AST_OV_CODE: assert property ((sel == 2'h1 || sel == 2'h2) && calm && i_fault == 23'h10
		|-> ##2 o_term_on == 4'h4) else $error("wrong code for overvoltage");
	AST_OTHER_CODE: assert property ((sel == 2'h1 || sel == 2'h2) && calm && i_fault == 23'h400000
		|-> ##2 o_term_on == 4'hF) else $error("wrong code for other fault");
	AST_HOLD_STEADY: assert property (o_trip && !o_retry_active && !i_psel && !$past(i_psel)
		&& $past(o_trip) |=> o_trip && $stable(o_term_on)) else $error("held fault code changed");
	COV_RETRY: cover property (o_retry_reset);
	COV_IRQ: cover property (o_trip && o_irq);
	COV_SHUT: cover property (o_out_shutoff);
	COV_DECEL: cover property (o_pf_decel);
endmodule

`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "frc_consts.svh"

module tb_top;
	localparam int unsigned SEC = 20;
	localparam int unsigned PHS = 30;
	localparam logic [8:0] ALL = 9'h1FF;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic rchk = 1'h0;
	logic pchk = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [22:0] fault = 23'h0;
	logic [3:0] term = 4'h0;
	logic [2:0] in_pl = 3'h0;
	logic out_pl = 1'h0;
	logic pready, pslverr, trip, ra, rr, clr, pfd, shut, irq;
	logic [31:0] prdata;
	logic [3:0] term_on, plc_code;
	logic [31:0] seed = 32'h528F6EF3;
	logic [31:0] r;
	logic [17:0] pe;
	logic [32:0] rq[$];
	logic [17:0] pq[$];
	int tq[$];
	int wcnt = 0;
	int cycles = 0;
	int bad_count = 0;
	int n_tests = 0;
	logic [3:0] code_tab [23] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA,
		4'hB, 4'hC, 4'hD, 4'hE, 4'hE, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};
	int rc[3] = '{1, 3, 6};
	logic [5:0] el[3] = '{6'h1B, 6'h1D, 6'h01};
	logic [3:0] rcd[3] = '{4'h2, 4'h4, 4'h5};

	frc_top #(.SEC_CYCLES(SEC), .PHASE_CYCLES(PHS)) uut (.i_core_clk(core_clk), .i_rst(rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .i_fault(fault), .i_term_func(term), .i_in_phase_loss(in_pl),
		.i_out_phase_loss(out_pl), .o_term_on(term_on), .o_trip(trip), .o_retry_active(ra),
		.o_retry_reset(rr), .o_clear_accum(clr), .o_pf_decel(pfd), .o_out_shutoff(shut), .o_irq(irq));
	frc_plc_model plc (.i_term_on(term_on), .o_code(plc_code));

	initial begin
		forever #50 core_clk = ~core_clk;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// All drivers start and end just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		rchk <= c;
		@(posedge core_clk);
		penable <= 1'h1;
		@(posedge core_clk);
		while (pready !== 1'h1) @(posedge core_clk);
		psel <= 1'h0;
		penable <= 1'h0;
		rchk <= 1'h0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d, 1'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rq.push_back(e);
		apb(1'h0, a, 32'h0, 1'h1);
	endtask
	task automatic pin(input logic [8:0] m, input logic [8:0] e);
		pq.push_back({m, e});
		pchk <= 1'h1;
		@(posedge core_clk);
		pchk <= 1'h0;
		@(posedge core_clk);
	endtask
	task automatic flt(input int c, input int n);
		fault <= 23'h1 << c;
		cyc(n);
		fault <= 23'h0;
		cyc(3);
	endtask
	// ----------------------------------------
	// Result monitor
	// ----------------------------------------
	task automatic cmp_rd(input logic [32:0] e, input logic [32:0] s);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected apb_read expected %h seen %h", e, s);
		end
	endtask
	task automatic cmp_pin(input logic [8:0] m, input logic [8:0] e, input logic [8:0] s);
		n_tests++;
		if ((s & m) !== (e & m)) begin
			bad_count++;
			$display("unexpected pins expected %h seen %h", e & m, s & m);
		end
	endtask
	task automatic cmp_rr(input int w);
		n_tests++;
		if (wcnt < w - 1 || wcnt > w + 2) begin
			bad_count++;
			$display("unexpected retry_wait expected %0d seen %0d", w, wcnt);
		end
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		wcnt <= (ra === 1'h1) ? wcnt + 1 : 0;
		if (rchk && psel && penable && pready === 1'h1) cmp_rd(rq.pop_front(), {pslverr, prdata});
		if (pchk) begin
			pe = pq.pop_front();
			cmp_pin(pe[17:9], pe[8:0], {shut, pfd, irq, trip, ra, plc_code});
		end
		// A retry nobody asked for has no note and fails
		if (rr === 1'h1) cmp_rr((tq.size() == 0) ? -100 : tq.pop_front());
		if (cycles == 9000) begin
			bad_count++;
			close_out();
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		cyc(16);
		rst <= 1'h0;
		@(posedge core_clk);
		rd(`FRC_REG_CTRL, 33'h20);
		rd(`FRC_REG_RETRY, 33'h100);
		rd(8'h40, 33'h100000000);
		wr(`FRC_REG_CTRL, 32'h28);
		for (int c = 0; c < 23; c++) begin
			if (c < 19 || c > 21) begin
				r = rnd();
				term <= r[3:0];
				fault <= (23'h1 << c) | (c[0] ? r[30:8] & ~((23'h2 << c) - 23'h1) & 23'h47FFFF : 23'h0);
				cyc(2);
				fault <= 23'h0;
				cyc(2);
				pin(ALL, {5'h02, code_tab[c]});
				wr(`FRC_REG_CMD, 32'h1);
				pin(ALL, 9'h000);
			end
		end
		wr(`FRC_REG_CTRL, 32'h30);
		term <= r[7:4];
		cyc(3);
		pin(ALL, {5'h00, r[7:4]});
		flt(2, 2);
		pin(ALL, 9'h023);
		wr(`FRC_REG_CMD, 32'h1);
		wr(`FRC_REG_RETRY, 32'h101);
		for (int v = 0; v < 6; v++) begin
			for (int k = 0; k < 3; k++) begin
				wr(`FRC_REG_CTRL, 32'h28 | v);
				if (el[k][v]) tq.push_back(SEC);
				flt(rc[k], 2);
				pin(ALL, {3'h0, ~el[k][v], el[k][v], rcd[k]});
				cyc(30);
				wr(`FRC_REG_CMD, {31'h0, ~el[k][v]});
				pin(ALL, 9'h000);
				cyc(90);
			end
		end
		wr(`FRC_REG_RETRY, 32'h001);
		wr(`FRC_REG_CTRL, 32'h28);
		tq.push_back(0);
		flt(0, 1);
		cyc(10);
		pin(ALL, 9'h000);
		wr(`FRC_REG_RETRY, 32'h101);
		tq.push_back(SEC);
		flt(1, 2);
		cyc(30);
		flt(1, 2);
		pin(ALL, 9'h02F);
		wr(`FRC_REG_CMD, 32'h1);
		wr(`FRC_REG_CTRL, 32'h29);
		flt(1, 2);
		flt(6, 2);
		pin(ALL, 9'h022);
		cyc(30);
		rd(`FRC_REG_RECORD, 33'h12);
		wr(`FRC_REG_CMD, 32'h1);
		wr(`FRC_REG_CTRL, 32'h28);
		wr(`FRC_REG_CMD, 32'h2);
		cyc(3);
		pin(ALL, 9'h021);
		cyc(40);
		wr(`FRC_REG_CMD, 32'h1);
		// Interrupt raised, cleared, then masked
		wr(`FRC_REG_RETRY, 32'h100);
		wr(`FRC_REG_INT_STAT, 32'hF);
		wr(`FRC_REG_INT_MASK, 32'h1);
		flt(0, 2);
		pin(ALL, 9'h061);
		rd(`FRC_REG_INT_STAT, 33'h1);
		wr(`FRC_REG_CMD, 32'h1);
		wr(`FRC_REG_INT_STAT, 32'h1);
		pin(ALL, 9'h000);
		flt(0, 2);
		wr(`FRC_REG_INT_MASK, 32'h0);
		pin(ALL, 9'h021);
		wr(`FRC_REG_CMD, 32'h1);
		// Phase loss guards
		wr(`FRC_REG_CTRL, 32'h08);
		out_pl <= 1'h1;
		cyc(10);
		pin(ALL, 9'h000);
		wr(`FRC_REG_CTRL, 32'h28);
		cyc(6);
		pin(ALL, 9'h02F);
		out_pl <= 1'h0;
		wr(`FRC_REG_CMD, 32'h1);
		wr(`FRC_REG_CTRL, 32'h68);
		in_pl <= 3'h4;
		cyc(PHS - 8);
		pin(ALL, 9'h000);
		in_pl <= 3'h0;
		cyc(4);
		in_pl <= 3'h4;
		cyc(PHS + 6);
		pin(ALL, 9'h02F);
		in_pl <= 3'h0;
		wr(`FRC_REG_CMD, 32'h1);
		wr(`FRC_REG_CTRL, 32'hE8);
		in_pl <= 3'h4;
		cyc(PHS + 6);
		pin(ALL, 9'h080);
		in_pl <= 3'h0;
		wr(`FRC_REG_CTRL, 32'h68);
		cyc(5);
		in_pl <= 3'h3;
		cyc(PHS + 6);
		pin(9'h13F, 9'h100);
		in_pl <= 3'h0;
		close_out();
	end
endmodule

bind frc_top frc_top_chk #(.SEC_CYCLES(SEC_CYCLES), .PHASE_CYCLES(PHASE_CYCLES)) chk (.i_core_clk, .i_rst,
	.i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .i_fault, .i_term_func, .o_term_on,
	.o_trip, .o_retry_active, .o_retry_reset, .o_clear_accum, .o_pf_decel, .o_out_shutoff, .o_irq);

`default_nettype wire
